// [psis_pkg.sv]
// shared constants, timing counts and state encoding of the pressure sensor target
`default_nettype none
package psis_pkg;
    // bus address of the target, seven-bit form
    localparam logic [6:0] TARGET_ADDR = 7'h28;
    // clock period of clk_sys
    localparam int CLK_PERIOD_NS = 4;
    // longest delays in their own unit, counts round down
    localparam int POWERUP_INTERFACE_DELAY_NS = 1000000;
    localparam int POWERUP_MEASURE_DELAY_NS = 2500000;
    localparam int WAKEUP_INTERFACE_DELAY_NS = 500000;
    localparam int WAKEUP_MEASURE_DELAY_NS = 2000000;
    localparam int POWERUP_INTERFACE_DELAY_CYC = POWERUP_INTERFACE_DELAY_NS / CLK_PERIOD_NS;
    localparam int POWERUP_MEASURE_DELAY_CYC = POWERUP_MEASURE_DELAY_NS / CLK_PERIOD_NS;
    localparam int WAKEUP_INTERFACE_DELAY_CYC = WAKEUP_INTERFACE_DELAY_NS / CLK_PERIOD_NS;
    localparam int WAKEUP_MEASURE_DELAY_CYC = WAKEUP_MEASURE_DELAY_NS / CLK_PERIOD_NS;
    // width of the start-up counters, covers the longest delay
    localparam int DELAY_CNT_W = 20;
    // conversion time of one command, in cycles
    localparam int CONV_CYC = 64;
    // count width and calibrated end points
    localparam int COUNT_W = 14;
    localparam logic [13:0] ZERO_10_90 = 14'h0666;
    localparam logic [13:0] FULL_10_90 = 14'h399A;
    localparam logic [13:0] ZERO_5_95 = 14'h0333;
    localparam logic [13:0] FULL_5_95 = 14'h3CCB;
    // command length limits
    localparam logic [1:0] MAX_CMD_BYTES = 2'h3;
    localparam logic [1:0] HS_CMD_BYTES = 2'h3;
    // status byte fields
    localparam int STAT_READY_BIT = 6;
    localparam int STAT_BUSY_BIT = 5;
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [13:0] RESULT_RST = 14'h0000;
    // target protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } psis_state_e;
endpackage
`default_nettype wire

// [psis_if.sv]
// interfaces between line front end, protocol core and measurement engine
`default_nettype none
interface psis_line_if;
    logic scl_rise; // one-cycle pulse, scl went high
    logic scl_fall; // one-cycle pulse, scl went low
    logic start; // one-cycle pulse, start or repeated start
    logic stop; // one-cycle pulse, stop condition
    logic sda_s; // synchronised data line level
    logic sleep_s; // synchronised sleep request
    logic hs_s; // synchronised high-speed mode select
    logic range_s; // synchronised range select, 1 = 5%-95%
    modport drv (output scl_rise, scl_fall, start, stop, sda_s, sleep_s, hs_s, range_s);
    modport use_side (input scl_rise, scl_fall, start, stop, sda_s, sleep_s, hs_s, range_s);
endinterface
interface psis_meas_if;
    logic cmd_go; // one-cycle pulse, command accepted on the bus
    logic [7:0] cmd_code; // first byte of that command
    logic busy; // level, command executing
    logic [13:0] result; // last pressure count
    logic if_ready; // level, bus interface usable
    logic meas_ready; // level, measurement path usable
    modport core (output cmd_go, cmd_code, input busy, result, if_ready, meas_ready);
    modport meas (input cmd_go, cmd_code, output busy, result, if_ready, meas_ready);
endinterface
`default_nettype wire

// [psis_line.sv]
// pin synchronisers and bus condition detection
`default_nettype none
module psis_line (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sleep_in,
    input wire logic hs_in,
    input wire logic range_in,
    psis_line_if.drv line
);
    localparam int NPIN = 5;
    logic [NPIN-1:0] pins; // raw pin vector
    logic [NPIN-1:0] sync2; // second stage, first stage never read elsewhere
    logic [1:0] prev_reg; // scl and sda one cycle back
    logic [1:0] prev_next;
    logic [3:0] evt_reg; // rise, fall, start, stop
    logic [3:0] evt_next;

    assign pins = {range_in, hs_in, sleep_in, sda_in, scl_in};

    // two flops per pin before any logic looks at it
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin // mode pins idle low
                    s1_reg <= (g < 2);
                    s2_reg <= (g < 2);
                end else begin
                    s1_reg <= pins[g];
                    s2_reg <= s1_reg;
                end
            end
            assign sync2[g] = s2_reg;
        end
    endgenerate

    // edge and condition decode on the settled levels
    always_comb begin
        prev_next = sync2[1:0];
        evt_next[3] = sync2[0] & ~prev_reg[0];
        evt_next[2] = ~sync2[0] & prev_reg[0];
        // data falling while clock stays high is a start
        evt_next[1] = sync2[0] & prev_reg[0] & prev_reg[1] & ~sync2[1];
        // data rising while clock stays high is a stop
        evt_next[0] = sync2[0] & prev_reg[0] & ~prev_reg[1] & sync2[1];
    end

    // register the decoded conditions
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_reg <= 2'h3;
            evt_reg <= 4'h0;
        end else begin
            prev_reg <= prev_next;
            evt_reg <= evt_next;
        end
    end

    assign line.scl_rise = evt_reg[3];
    assign line.scl_fall = evt_reg[2];
    assign line.start = evt_reg[1];
    assign line.stop = evt_reg[0];
    assign line.sda_s = prev_reg[1];
    assign line.sleep_s = sync2[2];
    assign line.hs_s = sync2[3];
    assign line.range_s = sync2[4];
endmodule // psis_line
`default_nettype wire

// [psis_meas.sv]
// start-up gating, command execution and pressure count scaling
`default_nettype none
module psis_meas #(
    parameter int PU_IF_CYC = psis_pkg::POWERUP_INTERFACE_DELAY_CYC,
    parameter int PU_MS_CYC = psis_pkg::POWERUP_MEASURE_DELAY_CYC,
    parameter int WU_IF_CYC = psis_pkg::WAKEUP_INTERFACE_DELAY_CYC,
    parameter int WU_MS_CYC = psis_pkg::WAKEUP_MEASURE_DELAY_CYC,
    parameter int CONV = psis_pkg::CONV_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sleep_s,
    input wire logic range_s,
    input wire logic [13:0] meas_raw,
    psis_meas_if.meas mif
);
    localparam int CW = psis_pkg::DELAY_CNT_W;
    logic [CW-1:0] if_cnt_reg, if_cnt_next; // cycles until interface usable
    logic [CW-1:0] ms_cnt_reg, ms_cnt_next; // cycles until analog path usable
    logic [15:0] conv_reg, conv_next; // remaining conversion cycles
    logic busy_reg, busy_next;
    logic [13:0] res_reg, res_next;
    logic if_rdy_reg, if_rdy_next;
    logic ms_rdy_reg, ms_rdy_next;
    logic [13:0] zero, span;
    logic [27:0] prod;

    // raw plus one so the top code lands on full scale
    always_comb begin
        zero = range_s ? psis_pkg::ZERO_5_95 : psis_pkg::ZERO_10_90;
        span = range_s ? (psis_pkg::FULL_5_95 - psis_pkg::ZERO_5_95)
                       : (psis_pkg::FULL_10_90 - psis_pkg::ZERO_10_90);
        prod = ({14'h0000, meas_raw} + 28'h1) * {14'h0000, span};
    end

    // delay counters, command state and result
    always_comb begin
        if_cnt_next = if_cnt_reg;
        ms_cnt_next = ms_cnt_reg;
        conv_next = conv_reg;
        busy_next = busy_reg;
        res_next = res_reg;
        if (sleep_s) begin
            // reload so the wake delays start when sleep ends
            if_cnt_next = CW'(WU_IF_CYC);
            ms_cnt_next = CW'(WU_MS_CYC);
        end else begin
            if (if_cnt_reg != '0) if_cnt_next = if_cnt_reg - 1'b1;
            if (ms_cnt_reg != '0) ms_cnt_next = ms_cnt_reg - 1'b1;
        end
        if (!busy_reg) begin
            // a command during execution is dropped, not queued
            if (mif.cmd_go) begin
                busy_next = 1'b1;
                conv_next = 16'(CONV);
            end
        end else if (ms_rdy_reg && !sleep_s) begin
            // conversion only advances once the analog path is up
            if (conv_reg != 16'h0000) begin
                conv_next = conv_reg - 16'h0001;
            end else begin
                res_next = zero + prod[27:14];
                busy_next = 1'b0;
            end
        end
        if_rdy_next = (if_cnt_next == '0) && !sleep_s;
        ms_rdy_next = (ms_cnt_next == '0) && !sleep_s;
    end

    // register all state; reset acts as power being applied
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            if_cnt_reg <= CW'(PU_IF_CYC);
            ms_cnt_reg <= CW'(PU_MS_CYC);
            conv_reg <= 16'h0000;
            busy_reg <= 1'b0;
            res_reg <= psis_pkg::RESULT_RST;
            if_rdy_reg <= 1'b0;
            ms_rdy_reg <= 1'b0;
        end else begin
            if_cnt_reg <= if_cnt_next;
            ms_cnt_reg <= ms_cnt_next;
            conv_reg <= conv_next;
            busy_reg <= busy_next;
            res_reg <= res_next;
            if_rdy_reg <= if_rdy_next;
            ms_rdy_reg <= ms_rdy_next;
        end
    end

    assign mif.busy = busy_reg;
    assign mif.result = res_reg;
    assign mif.if_ready = if_rdy_reg;
    assign mif.meas_ready = ms_rdy_reg;
endmodule // psis_meas
`default_nettype wire

// [psis_top.sv]
// pressure sensor bus target: protocol core joining line front end and measurement engine
// Notes on behaviour
// - answer only to seven-bit address 0x28
// - normal mode accepts one to three command bytes
// - result readable after busy clears
// - status byte readable at any time; here only once if_ready is set, not before or in sleep
// - start, stop, ack, repeated start all handled
// - never stretch clock, seven-bit addressing only
// - high-speed mode commands exactly three bytes
// - result is fourteen-bit unsigned count
// - 10-90 range zero reads 666
// - 10-90 range full scale reads 399A
// - 5-95 range zero reads 333
// - 5-95 range full scale reads 3CCB
// - interface usable 1 ms after power
// - measurement usable 2.5 ms after power
// - interface usable 0.5 ms after wake
// - measurement usable 2 ms after wake
`default_nettype none
module psis_top #(
    parameter int PU_IF_CYC = psis_pkg::POWERUP_INTERFACE_DELAY_CYC,
    parameter int PU_MS_CYC = psis_pkg::POWERUP_MEASURE_DELAY_CYC,
    parameter int WU_IF_CYC = psis_pkg::WAKEUP_INTERFACE_DELAY_CYC,
    parameter int WU_MS_CYC = psis_pkg::WAKEUP_MEASURE_DELAY_CYC,
    parameter int CONV = psis_pkg::CONV_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic sleep_in,
    input wire logic hs_in,
    input wire logic range_in,
    input wire logic [13:0] meas_raw,
    output logic busy,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic [1:0] cmd_len,
    output logic [23:0] cmd_bytes
);
    psis_line_if line ();
    psis_meas_if mif ();

    // pin front end
    psis_line u_line (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sleep_in(sleep_in),
        .hs_in(hs_in),
        .range_in(range_in),
        .line(line)
    );

    // delay gating and command execution
    psis_meas #(
        .PU_IF_CYC(PU_IF_CYC),
        .PU_MS_CYC(PU_MS_CYC),
        .WU_IF_CYC(WU_IF_CYC),
        .WU_MS_CYC(WU_MS_CYC),
        .CONV(CONV)
    ) u_meas (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sleep_s(line.sleep_s),
        .range_s(line.range_s),
        .meas_raw(meas_raw),
        .mif(mif)
    );

    psis_pkg::psis_state_e st_reg, st_next; // protocol state
    logic [3:0] bit_reg, bit_next; // bits moved in the current byte
    logic [7:0] sh_reg, sh_next; // shift register for both directions
    logic [1:0] rd_idx_reg, rd_idx_next; // index of the next read byte
    logic [1:0] wr_cnt_reg, wr_cnt_next; // command bytes collected
    logic [23:0] buf_reg, buf_next; // collected command bytes, first in top
    logic wr_act_reg, wr_act_next; // a write transfer is open
    logic nack_reg, nack_next; // master refused the last read byte
    logic oe_n_reg, oe_n_next; // low pulls sda low
    logic go_reg, go_next; // accept pulse to the engine
    logic [7:0] code_reg, code_next;
    logic [1:0] len_reg, len_next;
    logic busy_reg;
    logic issue; // the open write closes as a valid command

    // status first, then the count high part, then the low part
    function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic bsy, input logic rdy,
                                           input logic [13:0] res);
        logic [7:0] b;
        b = psis_pkg::BYTE_RST;
        unique case (idx)
            2'h0: begin
                b[psis_pkg::STAT_BUSY_BIT] = bsy;
                b[psis_pkg::STAT_READY_BIT] = rdy;
            end
            2'h1: b = {2'b00, res[13:8]};
            2'h2: b = res[7:0];
            2'h3: b = psis_pkg::BYTE_RST;
        endcase
        return b;
    endfunction

    // a write of the right length becomes a command when it ends
    always_comb begin
        issue = wr_act_reg && (wr_cnt_reg != 2'h0)
                && (!line.hs_s || wr_cnt_reg == psis_pkg::HS_CMD_BYTES);
    end

    // protocol next state; sda is only ever pulled low, scl never touched
    always_comb begin
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        rd_idx_next = rd_idx_reg;
        wr_cnt_next = wr_cnt_reg;
        buf_next = buf_reg;
        wr_act_next = wr_act_reg;
        nack_next = nack_reg;
        oe_n_next = oe_n_reg;
        go_next = 1'b0;
        code_next = code_reg;
        len_next = len_reg;
        if (line.start || line.stop) begin
            // both close an open write; repeated start reopens addressing
            if (issue) begin
                go_next = 1'b1;
                code_next = buf_reg[23:16];
                len_next = wr_cnt_reg;
            end
            wr_act_next = 1'b0;
            oe_n_next = 1'b1;
            bit_next = 4'h0;
            st_next = line.start ? psis_pkg::ST_ADDR : psis_pkg::ST_IDLE;
        end else begin
            unique case (st_reg)
                psis_pkg::ST_IDLE: begin
                    oe_n_next = 1'b1;
                end
                psis_pkg::ST_ADDR: begin
                    if (line.scl_rise) begin
                        sh_next = {sh_reg[6:0], line.sda_s};
                        bit_next = bit_reg + 4'h1;
                    end else if (line.scl_fall && bit_reg == 4'h8) begin
                        // other addresses and a not yet ready interface get no ack
                        if (sh_reg[7:1] == psis_pkg::TARGET_ADDR && mif.if_ready) begin
                            oe_n_next = 1'b0;
                            st_next = psis_pkg::ST_ADDR_ACK;
                        end else begin
                            st_next = psis_pkg::ST_IDLE;
                        end
                    end
                end
                psis_pkg::ST_ADDR_ACK: begin
                    if (line.scl_fall) begin
                        bit_next = 4'h0;
                        if (sh_reg[0]) begin
                            // read: every read opens with the status byte
                            sh_next = tx_byte(2'h0, busy_reg, mif.meas_ready, mif.result);
                            oe_n_next = tx_byte(2'h0, busy_reg, mif.meas_ready, mif.result) >> 7 != 8'h00;
                            rd_idx_next = 2'h1;
                            st_next = psis_pkg::ST_RD;
                        end else begin
                            oe_n_next = 1'b1;
                            wr_act_next = 1'b1;
                            wr_cnt_next = 2'h0;
                            buf_next = 24'h000000;
                            st_next = psis_pkg::ST_WR;
                        end
                    end
                end
                psis_pkg::ST_WR: begin
                    if (line.scl_rise) begin
                        sh_next = {sh_reg[6:0], line.sda_s};
                        bit_next = bit_reg + 4'h1;
                    end else if (line.scl_fall && bit_reg == 4'h8) begin
                        bit_next = 4'h0;
                        if (wr_cnt_reg != psis_pkg::MAX_CMD_BYTES) begin
                            // place byte by arrival order, first byte on top
                            unique case (wr_cnt_reg)
                                2'h0: buf_next[23:16] = sh_reg;
                                2'h1: buf_next[15:8] = sh_reg;
                                default: buf_next[7:0] = sh_reg;
                            endcase
                            wr_cnt_next = wr_cnt_reg + 2'h1;
                            oe_n_next = 1'b0;
                            st_next = psis_pkg::ST_WR_ACK;
                        end else begin
                            // a fourth byte is refused, the command stays three long
                            st_next = psis_pkg::ST_WR;
                        end
                    end
                end
                psis_pkg::ST_WR_ACK: begin
                    if (line.scl_fall) begin
                        oe_n_next = 1'b1;
                        st_next = psis_pkg::ST_WR;
                    end
                end
                psis_pkg::ST_RD: begin
                    if (line.scl_fall) begin
                        if (bit_reg == 4'h7) begin
                            oe_n_next = 1'b1;
                            st_next = psis_pkg::ST_RD_ACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_n_next = sh_reg[6];
                            bit_next = bit_reg + 4'h1;
                        end
                    end
                end
                psis_pkg::ST_RD_ACK: begin
                    if (line.scl_rise) begin
                        nack_next = line.sda_s;
                    end else if (line.scl_fall) begin
                        bit_next = 4'h0;
                        if (nack_reg) begin
                            st_next = psis_pkg::ST_IDLE;
                        end else begin
                            // data bytes follow status whether busy is set or clear
                            sh_next = tx_byte(rd_idx_reg, busy_reg, mif.meas_ready, mif.result);
                            oe_n_next = tx_byte(rd_idx_reg, busy_reg, mif.meas_ready, mif.result) >> 7 != 8'h00;
                            rd_idx_next = (rd_idx_reg == 2'h3) ? 2'h3 : rd_idx_reg + 2'h1;
                            st_next = psis_pkg::ST_RD;
                        end
                    end
                end
            endcase
        end
    end

    // register protocol state; outputs other than busy, cmd_bytes and the constant sda_out come straight from these flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= psis_pkg::ST_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= psis_pkg::BYTE_RST;
            rd_idx_reg <= 2'h0;
            wr_cnt_reg <= 2'h0;
            buf_reg <= 24'h000000;
            wr_act_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            go_reg <= 1'b0;
            code_reg <= psis_pkg::BYTE_RST;
            len_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            rd_idx_reg <= rd_idx_next;
            wr_cnt_reg <= wr_cnt_next;
            buf_reg <= buf_next;
            wr_act_reg <= wr_act_next;
            nack_reg <= nack_next;
            oe_n_reg <= oe_n_next;
            go_reg <= go_next;
            code_reg <= code_next;
            len_reg <= len_next;
        end
    end

    logic [23:0] bytes_reg; // command bytes as delivered
    // latch the delivered bytes with the accept pulse
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bytes_reg <= 24'h000000;
        end else if (go_next) begin
            bytes_reg <= buf_reg;
        end
    end

    assign busy_reg = mif.busy;
    assign mif.cmd_go = go_reg;
    assign mif.cmd_code = code_reg;
    assign sda_out = 1'b0; // open drain: level is always low, enable decides
    assign sda_oe_n = oe_n_reg;
    assign busy = mif.busy;
    assign cmd_strobe = go_reg;
    assign cmd_code = code_reg;
    assign cmd_len = len_reg;
    assign cmd_bytes = bytes_reg;
endmodule // psis_top
`default_nettype wire

// [psis_top_sva.sv]
// port assertions of the pressure sensor bus target
`default_nettype none
module psis_top_sva #(
    parameter int CONV = psis_pkg::CONV_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic hs_in,
    input wire logic sda_oe_n,
    input wire logic busy,
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_len,
    input wire logic [23:0] cmd_bytes
);
    logic [31:0] bcnt_reg, bcnt_next; // cycles busy so far
    // restarts when busy drops, so a short busy period shows at its fall
    always_comb begin
        bcnt_next = busy ? bcnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys) begin
        bcnt_reg <= sys_rst ? 32'h0 : bcnt_next;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rst_idle_a: assert property ($fell(sys_rst) |-> sda_oe_n && !busy && !cmd_strobe)
        else $error("outputs not idle after reset");
    strobe_pulse_a: assert property (cmd_strobe |=> !cmd_strobe) else $error("strobe too long");
    busy_rise_a: assert property (cmd_strobe && !busy |=> busy) else $error("busy not set");
    busy_min_a: assert property ($fell(busy) |-> bcnt_reg >= CONV) else $error("busy too short");
    len_ok_a: assert property (cmd_strobe |-> cmd_len != 2'h0) else $error("bad length");
    hs_len_a: assert property (cmd_strobe && hs_in && $past(hs_in, 8) |-> cmd_len == 2'h3)
        else $error("short command in fast mode");
    code_hold_a: assert property (!cmd_strobe |-> $stable(cmd_code)) else $error("code moved");
    sda_low_a: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("sda moved in clock high");
endmodule // psis_top_sva
bind psis_top psis_top_sva #(.CONV(CONV)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in),
    .hs_in(hs_in), .sda_oe_n(sda_oe_n), .busy(busy), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .cmd_len(cmd_len), .cmd_bytes(cmd_bytes));
`default_nettype wire

// [psis_master.sv]
// bus master model: drives clock and data, samples the wired data line
`default_nettype none
module psis_master (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: lines released, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // a third of a bit time
    task automatic gap;
        repeat (10) @(negedge clk_sys);
    endtask
    // data moves only while clock is low; the target is never waited on
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        gap();
        scl = 1'b1;
        gap();
        r = sda_line;
        scl = 1'b0;
        gap();
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ai, ao);
    endtask
    task automatic start_c;
        gap();
        scl = 1'b1;
        gap();
        sda_drv = 1'b0;
        gap();
        scl = 1'b0;
    endtask
    // stop, then bus free time of 2 us before any new start
    task automatic stop_c;
        sda_drv = 1'b0;
        gap();
        scl = 1'b1;
        gap();
        sda_drv = 1'b1;
        repeat (50) gap();
    endtask
endmodule // psis_master
`default_nettype wire

// [psis_top_bench.sv]
// self-checking bench of the pressure sensor bus target
`default_nettype none
module psis_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, sys_rst = 1'b1, hs_in = 1'b0, range_in = 1'b0, sleep_in = 1'b0;
    logic [13:0] meas_raw = 14'h0000;
    logic scl, sda_drv, sda_out, sda_oe_n, busy, cmd_strobe, ack;
    logic [7:0] cmd_code, rx;
    logic [1:0] cmd_len, got_len;
    logic [23:0] cmd_bytes, got_bytes;
    int err_total = 0, n_tests = 0, n_strobe = 0, cycles = 0;
    // open-drain data wire with pull-up
    wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
    // short start-up counts keep the run brief
    psis_top #(.PU_IF_CYC(400), .PU_MS_CYC(800), .WU_IF_CYC(300), .WU_MS_CYC(600), .CONV(2000)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .sleep_in(sleep_in), .hs_in(hs_in), .range_in(range_in), .meas_raw(meas_raw),
        .busy(busy), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_bytes(cmd_bytes));
    psis_master m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // catch each one-cycle command strobe; cut a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cmd_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
            got_len <= cmd_len;
            got_bytes <= cmd_bytes;
        end
        if (cycles == 80000) begin
            $display("MISMATCH %0t timeout", $time);
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // write of n bytes; a[4] the address ack, a[3-i] that of byte i
    task automatic wr(input logic [6:0] adr, input int n, output logic [4:0] a);
        m.start_c();
        m.byte_io({adr, 1'b0}, 1'b1, rx, a[4]);
        for (int i = 0; i < n; i++) m.byte_io(8'hA1 + 8'(i * 17), 1'b1, rx, a[3-i]);
        m.stop_c();
    endtask
    // read status, count high and count low, master ends with a nack
    task automatic rd(output logic [23:0] d);
        m.start_c();
        m.byte_io({7'h28, 1'b1}, 1'b1, rx, ack);
        m.byte_io(8'hFF, 1'b0, d[23:16], ack);
        m.byte_io(8'hFF, 1'b0, d[15:8], ack);
        m.byte_io(8'hFF, 1'b1, d[7:0], ack);
        m.stop_c();
    endtask
    task automatic s_start;
        logic [4:0] a;
        wr(7'h28, 0, a);
        chk(a[4], 1'b1);
        wr(7'h29, 0, a);
        chk(a[4], 1'b1);
        wr(7'h28, 0, a);
        chk(a[4], 1'b0);
        sleep_in = 1'b1;
        repeat (9) @(negedge clk_sys);
        sleep_in = 1'b0;
        wr(7'h28, 0, a);
        chk(a[4], 1'b1);
    endtask
    // normal 1 and 4 bytes, fast mode 2 and 3 bytes
    task automatic s_cmd;
        logic [4:0] a;
        int s;
        for (int k = 0; k < 4; k++) begin
            hs_in = (k > 1);
            s = n_strobe;
            wr(7'h28, (k == 0) ? 1 : (k == 1) ? 4 : k, a);
            chk(n_strobe - s, (k == 2) ? 0 : 1);
            if (k != 2) chk(got_len, (k == 0) ? 2'h1 : 2'h3);
            if (k == 1) chk({got_bytes, a[0]}, {24'hA1B2C3, 1'b1});
        end
        hs_in = 1'b0;
    endtask
    // end points of both ranges, status while busy, result after busy clears
    task automatic s_result;
        logic [4:0] a;
        logic [23:0] d;
        logic [13:0] z, f;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 2500 && busy !== 1'b0; i++) @(negedge clk_sys);
            range_in = j[1];
            meas_raw = j[0] ? 14'h3FFF : 14'h0000;
            z = j[1] ? 14'h0333 : 14'h0666;
            f = j[1] ? 14'h3CCB : 14'h399A;
            wr(7'h28, 1, a);
            rd(d);
            chk(d[23:16], 8'h60);
            for (int i = 0; i < 2500 && busy !== 1'b0; i++) @(negedge clk_sys);
            chk(busy, 1'b0);
            rd(d);
            chk(d, {8'h40, 2'b00, j[0] ? f : z});
        end
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk({sda_oe_n, busy, cmd_strobe}, 3'b100);
        s_start();
        s_cmd();
        s_result();
        stop_test();
    end
    task automatic stop_test;
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
endmodule // psis_top_bench
`default_nettype wire
